// ---- src/wpl_latch.sv ----
// Wake-up pending latch: 32 edge channels, pending set/clear, request routing.
// Assumes an APB3 master on pclk and asynchronous wake inputs.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module wpl_latch #(
  parameter int ADDR_W = 10,
  parameter int HALF_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [15:0]       wake_inputs_lower,
  input  wire logic [15:0]       wake_inputs_upper,
  output logic      [7:0]        irq_req,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 10) begin : g_chk_addr
    $error("ADDR_W too small for the register map");
  end
  if (HALF_W != wpl_pkg::HALF_CH) begin : g_chk_half
    $error("HALF_W must be 16");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Four request lines from sixteen channels and their 2-bit selects
  function automatic logic [3:0] wpl_route(input logic [15:0] act,
                                           input logic [31:0] sel);
    logic [3:0] r;
    r = 4'h0;
    for (int c = 0; c < 16; c++) begin
      if (act[c]) begin
        r[sel[2*c +: 2]] = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic wpl_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] idx);
    return (a == ADDR_W'({idx, 2'h0}));
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [31:0] sync1_ff;
  logic [31:0] sync2_ff;
  logic [31:0] sync3_ff;
  logic [31:0] nxt_sync1;
  logic [31:0] nxt_sync2;
  logic [31:0] nxt_sync3;
  logic [31:0] rise;
  logic [31:0] fall;
  logic [31:0] hw_set;

  wpl_pkg::wpl_cfg_t cfg_ff;
  wpl_pkg::wpl_cfg_t nxt_cfg;

  always_comb begin
    nxt_sync1 = {wake_inputs_upper, wake_inputs_lower};
    nxt_sync2 = sync1_ff;
    nxt_sync3 = sync2_ff;
    rise      = sync2_ff & ~sync3_ff;
    fall      = ~sync2_ff & sync3_ff;
    // Edge of selected polarity on enabled channels only
    hw_set    = cfg_ff.enable & ((~cfg_ff.polarity & rise) |
                                 (cfg_ff.polarity & fall));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      sync3_ff <= nxt_sync3;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic        ready_ff;
  logic        nxt_ready;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        err_ff;
  logic        nxt_err;
  logic        acc;
  logic        wr_done;
  logic        mapped;
  logic [31:0] rd_val;
  logic [31:0] pend_ff;
  logic [31:0] nxt_pend;
  logic [7:0]  stat_ff;
  logic [7:0]  nxt_stat;
  logic [7:0]  mask_ff;
  logic [7:0]  nxt_mask;

  always_comb begin
    acc     = psel & penable;
    wr_done = acc & ready_ff & pwrite;
    mapped  = 1'b1;
    rd_val  = 32'h0000_0000;
    unique case (1'b1)
      wpl_hit(paddr, wpl_pkg::IDX_POL_LO):   rd_val[15:0] = cfg_ff.polarity[15:0];
      wpl_hit(paddr, wpl_pkg::IDX_POL_HI):   rd_val[15:0] = cfg_ff.polarity[31:16];
      wpl_hit(paddr, wpl_pkg::IDX_EN_LO):    rd_val[15:0] = cfg_ff.enable[15:0];
      wpl_hit(paddr, wpl_pkg::IDX_EN_HI):    rd_val[15:0] = cfg_ff.enable[31:16];
      wpl_hit(paddr, wpl_pkg::IDX_IEN_LO):   rd_val[15:0] = cfg_ff.irq_enable[15:0];
      wpl_hit(paddr, wpl_pkg::IDX_IEN_HI):   rd_val[15:0] = cfg_ff.irq_enable[31:16];
      wpl_hit(paddr, wpl_pkg::IDX_RTA_LO):   rd_val[15:0] = cfg_ff.route[15:0];
      wpl_hit(paddr, wpl_pkg::IDX_RTB_LO):   rd_val[15:0] = cfg_ff.route[31:16];
      wpl_hit(paddr, wpl_pkg::IDX_RTA_HI):   rd_val[15:0] = cfg_ff.route[47:32];
      wpl_hit(paddr, wpl_pkg::IDX_RTB_HI):   rd_val[15:0] = cfg_ff.route[63:48];
      wpl_hit(paddr, wpl_pkg::IDX_PEND_LO):  rd_val[15:0] = pend_ff[15:0];
      wpl_hit(paddr, wpl_pkg::IDX_PEND_HI):  rd_val[15:0] = pend_ff[31:16];
      wpl_hit(paddr, wpl_pkg::IDX_CLR_LO),
      wpl_hit(paddr, wpl_pkg::IDX_CLR_HI):   rd_val = wpl_pkg::RD_UNDEF;
      wpl_hit(paddr, wpl_pkg::IDX_IRQ_STAT): rd_val[7:0] = stat_ff;
      wpl_hit(paddr, wpl_pkg::IDX_IRQ_MASK): rd_val[7:0] = mask_ff;
      default:                               mapped = 1'b0;
    endcase
    // One wait state: pready rises in the second access cycle
    nxt_ready = acc & ~ready_ff;
    nxt_rdata = (acc & ~ready_ff & ~pwrite) ? rd_val : 32'h0000_0000;
    nxt_err   = acc & ~ready_ff & ~mapped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      err_ff   <= 1'b0;
    end else begin
      ready_ff <= nxt_ready;
      rdata_ff <= nxt_rdata;
      err_ff   <= nxt_err;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and pending registers
  // ----------------------------------------------------------------
  logic [31:0] sw_set;
  logic [31:0] sw_clr;

  always_comb begin
    nxt_cfg = cfg_ff;
    sw_set  = 32'h0000_0000;
    sw_clr  = 32'h0000_0000;
    if (wr_done) begin
      if (wpl_hit(paddr, wpl_pkg::IDX_POL_LO))  nxt_cfg.polarity[15:0]    = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_POL_HI))  nxt_cfg.polarity[31:16]   = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_EN_LO))   nxt_cfg.enable[15:0]      = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_EN_HI))   nxt_cfg.enable[31:16]     = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_IEN_LO))  nxt_cfg.irq_enable[15:0]  = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_IEN_HI))  nxt_cfg.irq_enable[31:16] = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_RTA_LO))  nxt_cfg.route[15:0]       = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_RTB_LO))  nxt_cfg.route[31:16]      = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_RTA_HI))  nxt_cfg.route[47:32]      = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_RTB_HI))  nxt_cfg.route[63:48]      = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_PEND_LO)) sw_set[15:0]  = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_PEND_HI)) sw_set[31:16] = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_CLR_LO))  sw_clr[15:0]  = pwdata[15:0];
      if (wpl_hit(paddr, wpl_pkg::IDX_CLR_HI))  sw_clr[31:16] = pwdata[15:0];
    end
    // Set terms applied after the clear so they win
    nxt_pend = (pend_ff & ~sw_clr) | sw_set | hw_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff.polarity   <= {wpl_pkg::RST_HALF, wpl_pkg::RST_HALF};
      cfg_ff.enable     <= {wpl_pkg::RST_HALF, wpl_pkg::RST_HALF};
      cfg_ff.irq_enable <= {wpl_pkg::RST_HALF, wpl_pkg::RST_HALF};
      cfg_ff.route      <= {wpl_pkg::RST_ROUTE, wpl_pkg::RST_ROUTE};
      pend_ff           <= {wpl_pkg::RST_HALF, wpl_pkg::RST_HALF};
    end else begin
      cfg_ff            <= nxt_cfg;
      pend_ff           <= nxt_pend;
    end
  end

  // ----------------------------------------------------------------
  // Request routing and interrupt status
  // ----------------------------------------------------------------
  logic [31:0] act;
  logic [7:0]  nxt_req;
  logic [7:0]  req_ff;
  logic        irq_ff;
  logic        nxt_irq;
  logic [7:0]  stat_clr;

  always_comb begin
    act      = pend_ff & cfg_ff.irq_enable;
    nxt_req  = {wpl_route(act[31:16], cfg_ff.route[63:32]),
                wpl_route(act[15:0], cfg_ff.route[31:0])};
    nxt_mask = mask_ff;
    stat_clr = 8'h00;
    if (wr_done && wpl_hit(paddr, wpl_pkg::IDX_IRQ_MASK)) nxt_mask = pwdata[7:0];
    if (wr_done && wpl_hit(paddr, wpl_pkg::IDX_IRQ_STAT)) stat_clr = pwdata[7:0];
    // Active request lines are sticky events; set wins over clear
    nxt_stat = (stat_ff & ~stat_clr) | req_ff;
    nxt_irq  = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff  <= wpl_pkg::RST_IRQ;
      stat_ff <= wpl_pkg::RST_IRQ;
      mask_ff <= wpl_pkg::RST_IRQ;
      irq_ff  <= 1'b0;
    end else begin
      req_ff  <= nxt_req;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      irq_ff  <= nxt_irq;
    end
  end

  assign prdata  = rdata_ff;
  assign pready  = ready_ff;
  assign pslverr = err_ff;
  assign irq_req = req_ff;
  assign irq     = irq_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic wr_pend_lo;
  logic wr_clr_lo;
  logic rd_clr;
  assign wr_pend_lo = wr_done & wpl_hit(paddr, wpl_pkg::IDX_PEND_LO);
  assign wr_clr_lo  = wr_done & wpl_hit(paddr, wpl_pkg::IDX_CLR_LO);
  assign rd_clr     = psel & penable & ~pwrite & ~ready_ff &
                      (wpl_hit(paddr, wpl_pkg::IDX_CLR_LO) |
                       wpl_hit(paddr, wpl_pkg::IDX_CLR_HI));

  property p_hw_latch;
    @(posedge pclk) disable iff (!presetn)
    (|hw_set) |=> ((pend_ff & $past(hw_set)) == $past(hw_set));
  endproperty
  a_hw_latch: assert property (p_hw_latch) else $error("trigger not latched");

  property p_sw_set;
    @(posedge pclk) disable iff (!presetn)
    wr_pend_lo |=> ((pend_ff[15:0] & $past(pwdata[15:0])) == $past(pwdata[15:0]));
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("pending write did not set");

  property p_no_sw_drop;
    @(posedge pclk) disable iff (!presetn)
    !(wr_done && (wpl_hit(paddr, wpl_pkg::IDX_CLR_LO) || wpl_hit(paddr, wpl_pkg::IDX_CLR_HI)))
      |=> (($past(pend_ff) & ~pend_ff) == 32'h0000_0000);
  endproperty
  a_no_sw_drop: assert property (p_no_sw_drop) else $error("pending bit lost");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (wr_clr_lo && ((hw_set[15:0] & pwdata[15:0]) == 16'h0000))
      |=> ((pend_ff[15:0] & $past(pwdata[15:0])) == 16'h0000);
  endproperty
  a_clear: assert property (p_clear) else $error("clear write ignored");

  property p_clr_read;
    @(posedge pclk) disable iff (!presetn)
    rd_clr |=> (pready && prdata == wpl_pkg::RD_UNDEF);
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("clear read data wrong");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    !wr_done |=> ((pend_ff & ~$past(pend_ff) & ~$past(cfg_ff.enable)) == 32'h0000_0000);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled channel fired");

  property p_rise;
    @(posedge pclk) disable iff (!presetn)
    (cfg_ff.enable[0] && !cfg_ff.polarity[0] && $rose(sync2_ff[0])) |=> pend_ff[0];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");

  property p_fall;
    @(posedge pclk) disable iff (!presetn)
    (cfg_ff.enable[16] && cfg_ff.polarity[16] && $fell(sync2_ff[16])) |=> pend_ff[16];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");

  property p_route0;
    @(posedge pclk) disable iff (!presetn)
    (pend_ff[0] && cfg_ff.irq_enable[0] && cfg_ff.route[1:0] == 2'h0) |=> irq_req[0];
  endproperty
  a_route0: assert property (p_route0) else $error("line 0 not raised");

  property p_route_hi;
    @(posedge pclk) disable iff (!presetn)
    (pend_ff[16] && cfg_ff.irq_enable[16] && cfg_ff.route[33:32] == 2'h3) |=> irq_req[7];
  endproperty
  a_route_hi: assert property (p_route_hi) else $error("line 7 not raised");

  property p_ien_gate;
    @(posedge pclk) disable iff (!presetn)
    ((pend_ff & cfg_ff.irq_enable) == 32'h0000_0000) |=> (irq_req == 8'h00);
  endproperty
  a_ien_gate: assert property (p_ien_gate) else $error("request without enable");

  property p_irq_out;
    @(posedge pclk) disable iff (!presetn)
    ##1 (irq == |(stat_ff & mask_ff));
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq level mismatch");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");

endmodule

`default_nettype wire

// ---- src/wpl_pkg.sv ----
// Constants and types of the wake-up pending latch.
// Assumes an APB master on pclk; register byte address is four times the index.
package wpl_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_POL_LO   = 8'h80;
  localparam logic [7:0] IDX_POL_HI   = 8'hA0;
  localparam logic [7:0] IDX_EN_LO    = 8'h82;
  localparam logic [7:0] IDX_EN_HI    = 8'hA2;
  localparam logic [7:0] IDX_RTA_LO   = 8'h84;
  localparam logic [7:0] IDX_RTA_HI   = 8'hA4;
  localparam logic [7:0] IDX_RTB_LO   = 8'h86;
  localparam logic [7:0] IDX_RTB_HI   = 8'hA6;
  localparam logic [7:0] IDX_PEND_LO  = 8'h88;
  localparam logic [7:0] IDX_PEND_HI  = 8'hA8;
  localparam logic [7:0] IDX_CLR_LO   = 8'h8A;
  localparam logic [7:0] IDX_CLR_HI   = 8'hAA;
  localparam logic [7:0] IDX_IEN_LO   = 8'h8C;
  localparam logic [7:0] IDX_IEN_HI   = 8'hAC;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hB0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hB2;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          HALF_CH      = 16;
  localparam int          NUM_CH       = 32;
  localparam int          NUM_REQ      = 8;
  localparam logic [15:0] RST_HALF     = 16'h0000;
  localparam logic [31:0] RST_ROUTE    = 32'h0000_0000;
  localparam logic [7:0]  RST_IRQ      = 8'h00;
  localparam logic [31:0] RD_UNDEF     = 32'h0000_0000;
  localparam int          APB_WAIT_CYC = 1;

  // ----------------------------------------------------------------
  // Channel configuration, both halves packed low to high
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] polarity;
    logic [31:0] enable;
    logic [31:0] irq_enable;
    logic [63:0] route;
  } wpl_cfg_t;

endpackage

// ---- testbench/wpl_latch_bench.sv ----
// Self-checking bench of the wake-up pending latch over APB.
// Assumes wpl_pkg, wpl_latch and wpl_wake_src are compiled before it.
`timescale 1ns/1ns
`default_nettype none

module wpl_latch_bench;
  typedef struct {
    logic [7:0]  widx;
    logic [31:0] wdat;
    logic [7:0]  ridx;
    logic [31:0] exp;
  } wpl_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd, level_req;
  logic [7:0]  irq_req;
  logic [15:0] wake_lo, wake_hi;
  int          errors, check_count;
  wpl_row_t    rows[12];
  logic [7:0]  rst_idx[11];

  wpl_latch dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_inputs_lower(wake_lo), .wake_inputs_upper(wake_hi),
    .irq_req(irq_req), .irq(irq));

  wpl_wake_src src_u (.pclk(pclk), .presetn(presetn), .level_req(level_req),
    .wake_inputs_lower(wake_lo), .wake_inputs_upper(wake_hi));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string w);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: no pready", $time);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'h0}, d);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [31:0] e, input string w);
    apb(1'b0, {i, 2'h0}, 32'h0000_0000);
    check(rd, e, w);
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 10'h000; pwdata = 32'h0000_0000; level_req = 32'h0000_0000;
    errors = 0; check_count = 0;
    rows[0] = '{wpl_pkg::IDX_POL_LO, 32'h0000_A5A5, wpl_pkg::IDX_POL_LO, 32'h0000_A5A5};
    rows[1] = '{wpl_pkg::IDX_EN_HI, 32'hFFFF_1234, wpl_pkg::IDX_EN_HI, 32'h0000_1234};
    rows[2] = '{wpl_pkg::IDX_RTB_HI, 32'h0000_C3C3, wpl_pkg::IDX_RTB_HI, 32'h0000_C3C3};
    rows[3] = '{wpl_pkg::IDX_IEN_LO, 32'h0000_00FF, wpl_pkg::IDX_IEN_LO, 32'h0000_00FF};
    rows[4] = '{wpl_pkg::IDX_IRQ_MASK, 32'h0000_01F0, wpl_pkg::IDX_IRQ_MASK, 32'h0000_00F0};
    rows[5] = '{wpl_pkg::IDX_PEND_HI, 32'h0000_8001, wpl_pkg::IDX_PEND_HI, 32'h0000_8001};
    rows[6] = '{wpl_pkg::IDX_PEND_HI, 32'h0000_0000, wpl_pkg::IDX_PEND_HI, 32'h0000_8001};
    rows[7] = '{wpl_pkg::IDX_CLR_HI, 32'h0000_0001, wpl_pkg::IDX_PEND_HI, 32'h0000_8000};
    rows[8] = '{wpl_pkg::IDX_CLR_HI, 32'h0000_0000, wpl_pkg::IDX_CLR_HI, wpl_pkg::RD_UNDEF};
    rows[9] = '{wpl_pkg::IDX_POL_HI, 32'h0000_3C3C, wpl_pkg::IDX_POL_HI, 32'h0000_3C3C};
    rows[10] = '{wpl_pkg::IDX_EN_LO, 32'h0000_8421, wpl_pkg::IDX_EN_LO, 32'h0000_8421};
    rows[11] = '{wpl_pkg::IDX_RTB_LO, 32'h0000_5A5A, wpl_pkg::IDX_RTB_LO, 32'h0000_5A5A};
    rst_idx = '{wpl_pkg::IDX_POL_LO, wpl_pkg::IDX_EN_HI, wpl_pkg::IDX_RTB_HI,
      wpl_pkg::IDX_IEN_LO, wpl_pkg::IDX_IRQ_MASK, wpl_pkg::IDX_PEND_HI,
      wpl_pkg::IDX_PEND_LO, wpl_pkg::IDX_IRQ_STAT, wpl_pkg::IDX_POL_HI,
      wpl_pkg::IDX_EN_LO, wpl_pkg::IDX_RTB_LO};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // ----------------------------------------------------------------
    // Table of write then read cases
    // ----------------------------------------------------------------
    foreach (rows[k]) begin
      wr(rows[k].widx, rows[k].wdat);
      rdc(rows[k].ridx, rows[k].exp, "table row");
    end
    $display("test table done");
    // ----------------------------------------------------------------
    // Reset in mid-run clears every register the table wrote, plus pending low and irq status
    // ----------------------------------------------------------------
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_idx[k]) rdc(rst_idx[k], 32'h0000_0000, "reset value");
    check({23'h0, irq, irq_req}, 32'h0000_0000, "irq after reset");
    $display("test reset done");
    // Setup order, ch1 falling, ch0 to line 2, ch16 to line 7
    level_req <= 32'h0000_0002;
    wr(wpl_pkg::IDX_EN_LO, 32'h0000_0000);
    wr(wpl_pkg::IDX_EN_HI, 32'h0000_0000);
    wr(wpl_pkg::IDX_IEN_LO, 32'h0000_0000);
    wr(wpl_pkg::IDX_IEN_HI, 32'h0000_0000);
    wr(wpl_pkg::IDX_POL_LO, 32'h0000_0002);
    wr(wpl_pkg::IDX_CLR_LO, 32'h0000_FFFF);
    wr(wpl_pkg::IDX_CLR_HI, 32'h0000_FFFF);
    wr(wpl_pkg::IDX_RTA_LO, 32'h0000_0006);
    wr(wpl_pkg::IDX_RTA_HI, 32'h0000_0003);
    wr(wpl_pkg::IDX_IEN_LO, 32'h0000_0001);
    wr(wpl_pkg::IDX_IEN_HI, 32'h0000_0001);
    wr(wpl_pkg::IDX_EN_LO, 32'h0000_0003);
    wr(wpl_pkg::IDX_EN_HI, 32'h0000_0001);
    // ch0 rises, ch1 falls, ch2 rises while disabled, ch16 rises
    level_req <= 32'h0001_0005;
    repeat (10) @(posedge pclk);
    rdc(wpl_pkg::IDX_PEND_LO, 32'h0000_0003, "edges low");
    rdc(wpl_pkg::IDX_PEND_HI, 32'h0000_0001, "edges high");
    check({24'h0, irq_req}, 32'h0000_0084, "request lines");
    rdc(wpl_pkg::IDX_IRQ_STAT, 32'h0000_0084, "irq status");
    check({31'h0, irq}, 32'h0000_0000, "irq masked");
    wr(wpl_pkg::IDX_IRQ_MASK, 32'h0000_0004);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0000_0001, "irq unmasked");
    wr(wpl_pkg::IDX_CLR_LO, 32'h0000_0001);
    wr(wpl_pkg::IDX_CLR_HI, 32'h0000_0001);
    rdc(wpl_pkg::IDX_PEND_LO, 32'h0000_0002, "clear low");
    rdc(wpl_pkg::IDX_PEND_HI, 32'h0000_0000, "clear high");
    wr(wpl_pkg::IDX_IRQ_STAT, 32'h0000_00FF);
    repeat (2) @(posedge pclk);
    check({23'h0, irq, irq_req}, 32'h0000_0000, "irq cleared");
    rdc(wpl_pkg::IDX_IRQ_STAT, 32'h0000_0000, "status cleared");
    $display("test edges and irq done");
    // Polarity change of ch0 and ch16 to falling, then both fall
    wr(wpl_pkg::IDX_EN_LO, 32'h0000_0002);
    wr(wpl_pkg::IDX_EN_HI, 32'h0000_0000);
    wr(wpl_pkg::IDX_POL_LO, 32'h0000_0003);
    wr(wpl_pkg::IDX_POL_HI, 32'h0000_0001);
    wr(wpl_pkg::IDX_CLR_LO, 32'h0000_0001);
    wr(wpl_pkg::IDX_CLR_HI, 32'h0000_0001);
    wr(wpl_pkg::IDX_EN_LO, 32'h0000_0003);
    wr(wpl_pkg::IDX_EN_HI, 32'h0000_0001);
    level_req <= 32'h0000_0004;
    repeat (10) @(posedge pclk);
    rdc(wpl_pkg::IDX_PEND_LO, 32'h0000_0003, "falling ch0");
    rdc(wpl_pkg::IDX_PEND_HI, 32'h0000_0001, "falling ch16");
    $display("test polarity change done");
    // ----------------------------------------------------------------
    // Every select code on both halves
    // ----------------------------------------------------------------
    wr(wpl_pkg::IDX_PEND_HI, 32'h0000_0001);
    for (int c = 0; c < 4; c++) begin
      wr(wpl_pkg::IDX_RTA_LO, 32'(c));
      wr(wpl_pkg::IDX_RTA_HI, 32'(c));
      repeat (2) @(posedge pclk);
      check({24'h0, irq_req}, {24'h0, 8'h01 << c | 8'h10 << c}, "route");
    end
    $display("test routing done");
    // Unmapped and misaligned accesses
    apb(1'b0, 10'h000, 32'h0000_0000);
    check({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
    apb(1'b1, 10'h221, 32'h0000_FFFF);
    check({31'h0, err}, 32'h0000_0001, "misaligned write");
    rdc(wpl_pkg::IDX_PEND_LO, 32'h0000_0003, "write ignored");
    $display("test unmapped done");
    // Ch0 rises (no trigger), then its fall lands on the clear's write edge
    level_req <= 32'h0000_0005;
    wr(wpl_pkg::IDX_CLR_LO, 32'h0000_0003);
    level_req <= 32'h0000_0004;
    wr(wpl_pkg::IDX_CLR_LO, 32'h0000_0001);
    rdc(wpl_pkg::IDX_PEND_LO, 32'h0000_0001, "set beats clear");
    $display("test set beats clear done");
    give_verdict();
  end
endmodule

`default_nettype wire

// ---- testbench/wpl_wake_src.sv ----
// Wake pin source model facing the wake inputs of the latch.
// Assumes the bench requests pin levels on level_req just after pclk edges.
`timescale 1ns/1ns
`default_nettype none

module wpl_wake_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] level_req,
  output logic      [15:0] wake_inputs_lower,
  output logic      [15:0] wake_inputs_upper
);
  logic [31:0] pins_ff = 32'h5A5A_A5A5;
  logic [1:0]  hold_ff = 2'h0;

  assign wake_inputs_lower = pins_ff[15:0];
  assign wake_inputs_upper = pins_ff[31:16];

  always @(posedge pclk) begin
    if (!presetn) begin
      // Floating pins show changing levels while in reset
      pins_ff <= ~pins_ff;
      hold_ff <= 2'h0;
    end else if (hold_ff == 2'h0 && level_req != pins_ff) begin
      // Each new level stands at least two cycles
      pins_ff <= level_req;
      hold_ff <= 2'h2;
    end else if (hold_ff != 2'h0) begin
      hold_ff <= hold_ff - 2'h1;
    end
  end
endmodule

`default_nettype wire
